// File: inc/dacfg_pkg.sv
// dacfg_pkg: shared constants and types for the dual converter control block
package dacfg_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] CMREF_ADDR  = 8'h08;
   localparam logic [7:0] SAMPA_ADDR  = 8'h0C;
   localparam logic [7:0] SAMPB_ADDR  = 8'h10;
   // ctrl fields
   localparam int CTRL_FMT_LSB  = 0;
   localparam int CTRL_DIV_LSB  = 2;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_BIAS_BIT = 6;
   localparam int CTRL_SOFT_BIT = 7;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   // common-mode code: 0 is 0.45 V, step 0.15 V, 6 is 1.35 V
   localparam logic [2:0] CMREF_RESET = 3'h3;
   localparam logic [2:0] CMREF_MAX   = 3'h6;
   // strap levels
   localparam logic [1:0] STRAP_GND  = 2'h0;
   localparam logic [1:0] STRAP_SUP  = 2'h1;
   localparam logic [1:0] STRAP_OPEN = 2'h2;
   // timing
   localparam int LATENCY_CYC = 9;
   localparam int STAGES      = 10;
   localparam int HALF_STEPS  = 2 * LATENCY_CYC - STAGES;
   typedef enum logic [2:0] {
      DACFG_FMT_TWOS = 3'b001,
      DACFG_FMT_OBIN = 3'b010,
      DACFG_FMT_GRAY = 3'b100
   } dacfg_fmt_e;
   typedef enum logic [2:0] {
      DACFG_BUS_DUAL = 3'b001,
      DACFG_BUS_MUXA = 3'b010,
      DACFG_BUS_MUXB = 3'b100
   } dacfg_bus_e;
endpackage

// File: src/dacfg_buf2.sv
// dacfg_buf2: two-entry valid/ready buffer for sample pairs
`timescale 1ns/10ps
`default_nettype none
module dacfg_buf2
   import dacfg_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic        in_valid_in,
   input  wire logic [21:0] in_data_in,
   output var  logic        in_ready_out,
   output var  logic        out_valid_out,
   output var  logic [21:0] out_data_out,
   input  wire logic        out_ready_in
);
   typedef struct packed {
      logic [1:0][21:0] mem;
      logic             wptr;
      logic             rptr;
      logic [1:0]       cnt;
   } dacfg_buf_s;
   dacfg_buf_s st_ff, nxt_st;
   logic push, pop;
   always_comb begin
      nxt_st = st_ff;
      push = in_valid_in && (st_ff.cnt != 2'h2);
      pop  = out_ready_in && (st_ff.cnt != 2'h0);
      if (push) begin
         nxt_st.mem[st_ff.wptr] = in_data_in;
         nxt_st.wptr = ~st_ff.wptr;
      end
      if (pop) begin
         nxt_st.rptr = ~st_ff.rptr;
      end
      nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign in_ready_out  = (st_ff.cnt != 2'h2);
   assign out_valid_out = (st_ff.cnt != 2'h0);
   assign out_data_out  = st_ff.mem[st_ff.rptr];
   never_over_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) st_ff.cnt <= 2'h2)
      else $error("buffer count above two");
endmodule
`default_nettype wire

// File: src/dacfg_serial.sv
// dacfg_serial: serial configuration port, 16-bit write cycles on the shared pins
`timescale 1ns/10ps
`default_nettype none
module dacfg_serial
   import dacfg_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       enable_in,
   input  wire logic       sel_n_in,
   input  wire logic       sdata_in,
   input  wire logic       sclk_in,
   output var  logic       wr_out,
   output var  logic [6:0] addr_out,
   output var  logic [7:0] data_out
);
   typedef struct packed {
      logic [15:0] shift;
      logic [4:0]  cnt;
      logic        sclk_d;
      logic        wr;
   } dacfg_ser_s;
   dacfg_ser_s st_ff, nxt_st;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_d = sclk_in;
      nxt_st.wr = 1'b0;
      if (!enable_in || sel_n_in) begin
         nxt_st.cnt = 5'h00;
      end else if (sclk_in && !st_ff.sclk_d && st_ff.cnt != 5'h10) begin
         nxt_st.shift = {st_ff.shift[14:0], sdata_in};
         nxt_st.cnt = st_ff.cnt + 5'h01;
         // first bit zero marks a write
         if (st_ff.cnt == 5'h0F && !st_ff.shift[14]) begin
            nxt_st.wr = 1'b1;
         end
      end
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign wr_out   = st_ff.wr;
   assign addr_out = st_ff.shift[14:8];
   assign data_out = st_ff.shift[7:0];
endmodule
`default_nettype wire

// File: src/dacfg_top.sv
// dacfg_top: control and output side of a dual 10-bit pipelined converter
// Overview of operation
// - port-select high: straps; low: serial port
// - serial mode: shared pins are select, data, clock
// - power-down pin high forces power-down state
// - parallel mode: power-down falling edge resets config
// - result appears nine sample cycles after sampling
// - ten stages, one stage per half cycle
// - format strap: gnd twos, supply offset, open gray
// - divider strap: gnd /1, supply /2, open /4
// - bus strap: gnd dual, supply mux on A
// - bus strap open: mux on B pins
// - mux bus: owning channel first, then other
// - ten-bit output words, bit 9 msb
// - per-channel over-range flag output
// - per-channel data clock output
// - sync input aligns divider phase
// - common mode 0.45-1.35 V, 0.15 V steps, default 0.90
// - bias resistors only when enabled by serial write
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dacfg_top
   import dacfg_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        host_port_select_n_in,
   input  wire logic        power_down_pin_in,
   input  wire logic [1:0]  serial_in_or_format_strap_in,
   input  wire logic [1:0]  serial_clock_or_divider_strap_in,
   input  wire logic [1:0]  chip_select_or_bus_mode_strap_in,
   input  wire logic        sync_in,
   input  wire logic [9:0]  chan_a_raw_in,
   input  wire logic [9:0]  chan_b_raw_in,
   input  wire logic        chan_a_ovr_raw_in,
   input  wire logic        chan_b_ovr_raw_in,
   input  wire logic        rx_ready_in,
   output var  logic [9:0]  chan_a_sample_bus_out,
   output var  logic [9:0]  chan_a_sample_bus_oe_out,
   output var  logic [9:0]  chan_b_sample_bus_out,
   output var  logic [9:0]  chan_b_sample_bus_oe_out,
   output var  logic        chan_a_over_range_out,
   output var  logic        chan_b_over_range_out,
   output var  logic        chan_a_output_clock_out,
   output var  logic        chan_b_output_clock_out,
   output var  logic        powered_down_out,
   output var  logic        bias_enable_out,
   output var  logic [2:0]  cm_ref_code_out
);
   typedef struct packed {
      logic [1:0]       rst_sync;
      logic             pd_d;
      logic [7:0]       ctrl;
      logic [2:0]       cmref;
      logic [1:0]       div_cnt;
      logic             sync_d;
      logic             tick;
      logic [HALF_STEPS-1:0][21:0] pipe;
      logic [HALF_STEPS-1:0]       pvld;
      logic [21:0]      hold;
      logic             phase;
      logic [9:0]       qa;
      logic [9:0]       qb;
      logic [9:0]       oea;
      logic [9:0]       oeb;
      logic             ova;
      logic             ovb;
      logic             dca;
      logic             dcb;
      logic [31:0]      rdata;
      logic             rdy;
      logic             err;
   } dacfg_top_s;
   dacfg_top_s st_ff, nxt_st;
   logic        rst_n;
   logic        ser_wr;
   logic [6:0]  ser_addr;
   logic [7:0]  ser_data;
   logic        buf_in_ready;
   logic        buf_valid;
   logic [21:0] buf_data;
   logic        buf_take;
   logic        serial_mode;
   logic [1:0]  fmt_sel;
   logic [1:0]  div_sel;
   logic [1:0]  bus_sel;
   dacfg_fmt_e  fmt;
   dacfg_bus_e  bus;
   logic [9:0]  wa;
   logic [9:0]  wb;
   logic [2:0]  div_lim;
   assign rst_n = st_ff.rst_sync[1];
   assign serial_mode = !host_port_select_n_in;
   dacfg_serial u_ser (
      .clock_in (clock_in),
      .rst_n_in (rst_n),
      .enable_in(serial_mode),
      .sel_n_in (chip_select_or_bus_mode_strap_in[0]),
      .sdata_in (serial_in_or_format_strap_in[0]),
      .sclk_in  (serial_clock_or_divider_strap_in[0]),
      .wr_out   (ser_wr),
      .addr_out (ser_addr),
      .data_out (ser_data)
   );
   dacfg_buf2 u_buf (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n),
      .in_valid_in  (st_ff.pvld[HALF_STEPS-1]),
      .in_data_in   (st_ff.pipe[HALF_STEPS-1]),
      .in_ready_out (buf_in_ready),
      .out_valid_out(buf_valid),
      .out_data_out (buf_data),
      .out_ready_in (buf_take)
   );
   assign fmt_sel = serial_mode ? st_ff.ctrl[CTRL_FMT_LSB +: 2]  : serial_in_or_format_strap_in;
   assign div_sel = serial_mode ? st_ff.ctrl[CTRL_DIV_LSB +: 2]  : serial_clock_or_divider_strap_in;
   assign bus_sel = serial_mode ? st_ff.ctrl[CTRL_MODE_LSB +: 2] : chip_select_or_bus_mode_strap_in;
   always_comb begin
      case (fmt_sel)
         STRAP_GND: fmt = DACFG_FMT_TWOS;
         STRAP_SUP: fmt = DACFG_FMT_OBIN;
         default:   fmt = DACFG_FMT_GRAY;
      endcase
      // open strap puts mux on B
      case (bus_sel)
         STRAP_GND: bus = DACFG_BUS_DUAL;
         STRAP_SUP: bus = DACFG_BUS_MUXA;
         default:   bus = DACFG_BUS_MUXB;
      endcase
      case (div_sel)
         STRAP_GND: div_lim = 3'h1;
         STRAP_SUP: div_lim = 3'h2;
         default:   div_lim = 3'h4;
      endcase
   end
   // raw inputs are offset binary; convert per format
   function automatic logic [9:0] fmt_word(input logic [9:0] w, input dacfg_fmt_e f);
      case (f)
         DACFG_FMT_TWOS: fmt_word = {~w[9], w[8:0]};
         DACFG_FMT_OBIN: fmt_word = w;
         DACFG_FMT_GRAY: fmt_word = w ^ (w >> 1);
         default:        fmt_word = w;
      endcase
   endfunction
   assign wa = fmt_word(buf_data[9:0], fmt);
   assign wb = fmt_word(buf_data[20:11], fmt);
   // pop when the outputs update, in mux mode only on the second word, so no word is skipped or repeated
   assign buf_take = buf_valid && rx_ready_in && !power_down_pin_in
                     && (bus == DACFG_BUS_DUAL || st_ff.phase);
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
      nxt_st.pd_d = power_down_pin_in;
      nxt_st.sync_d = sync_in;
      nxt_st.rdy = 1'b0;
      nxt_st.err = 1'b0;
      if (sync_in && !st_ff.sync_d) begin
         nxt_st.div_cnt = 2'h0;
         nxt_st.tick = 1'b0;
      end else if ({1'b0, st_ff.div_cnt} + 3'h1 >= div_lim) begin
         nxt_st.div_cnt = 2'h0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
         nxt_st.tick = 1'b0;
      end
      nxt_st.pipe[0] = {chan_b_ovr_raw_in, chan_b_raw_in, chan_a_ovr_raw_in, chan_a_raw_in};
      nxt_st.pvld[0] = st_ff.tick && buf_in_ready;
      for (int i = 1; i < HALF_STEPS; i++) begin
         nxt_st.pipe[i] = st_ff.pipe[i-1];
         nxt_st.pvld[i] = st_ff.pvld[i-1];
      end
      if (power_down_pin_in) begin
         nxt_st.oea = 10'h000;
         nxt_st.oeb = 10'h000;
      end else begin
         nxt_st.oea = (bus == DACFG_BUS_MUXB) ? 10'h000 : 10'h3FF;
         nxt_st.oeb = (bus == DACFG_BUS_MUXA) ? 10'h000 : 10'h3FF;
      end
      if (buf_valid && rx_ready_in && !power_down_pin_in) begin
         if (bus == DACFG_BUS_DUAL) begin
            nxt_st.qa = wa;
            nxt_st.qb = wb;
            nxt_st.ova = buf_data[10];
            nxt_st.ovb = buf_data[21];
            nxt_st.dca = ~st_ff.dca;
            nxt_st.dcb = ~st_ff.dcb;
         end else begin
            nxt_st.phase = ~st_ff.phase;
            if ((bus == DACFG_BUS_MUXA) ^ st_ff.phase) begin
               nxt_st.qa = wa;
               nxt_st.qb = wa;
               nxt_st.ova = buf_data[10];
               nxt_st.ovb = buf_data[10];
            end else begin
               nxt_st.qa = wb;
               nxt_st.qb = wb;
               nxt_st.ova = buf_data[21];
               nxt_st.ovb = buf_data[21];
            end
            nxt_st.dca = ~st_ff.dca;
            nxt_st.dcb = ~st_ff.dcb;
         end
      end
      // apb slave, one wait state per access
      if (psel && penable && !st_ff.rdy) begin
         nxt_st.rdy = 1'b1;
         nxt_st.rdata = 32'h0000_0000;
         case (paddr)
            CTRL_ADDR: begin
               // apb write keeps the bias bit; only a serial write sets it
               if (pwrite) begin
                  nxt_st.ctrl = pwdata[7:0];
                  nxt_st.ctrl[CTRL_BIAS_BIT] = st_ff.ctrl[CTRL_BIAS_BIT];
               end
               nxt_st.rdata = {24'h00_0000, st_ff.ctrl};
            end
            STATUS_ADDR: nxt_st.rdata = {28'h000_0000, buf_valid, st_ff.tick, power_down_pin_in, serial_mode};
            CMREF_ADDR: begin
               if (pwrite && pwdata[2:0] <= CMREF_MAX) nxt_st.cmref = pwdata[2:0];
               nxt_st.rdata = {29'h0000_0000, st_ff.cmref};
            end
            SAMPA_ADDR: nxt_st.rdata = {21'h00_0000, st_ff.ova, st_ff.qa};
            SAMPB_ADDR: nxt_st.rdata = {21'h00_0000, st_ff.ovb, st_ff.qb};
            default: nxt_st.err = 1'b1;
         endcase
      end
      if (ser_wr && ser_addr == 7'h08) begin
         nxt_st.ctrl[CTRL_BIAS_BIT] = ser_data[CTRL_BIAS_BIT];
         nxt_st.cmref = (ser_data[2:0] <= CMREF_MAX) ? ser_data[2:0] : st_ff.cmref;
      end
      if (!serial_mode) begin
         nxt_st.ctrl[CTRL_BIAS_BIT] = 1'b0;
      end
      if ((!serial_mode && st_ff.pd_d && !power_down_pin_in) || st_ff.ctrl[CTRL_SOFT_BIT]) begin
         nxt_st.ctrl = CTRL_RESET;
         nxt_st.cmref = CMREF_RESET;
      end
   end
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_ff <= '0;
         st_ff.cmref <= CMREF_RESET;
      end else if (!st_ff.rst_sync[1]) begin
         st_ff <= '0;
         st_ff.rst_sync <= {st_ff.rst_sync[0], 1'b1};
         st_ff.cmref <= CMREF_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign prdata = st_ff.rdata;
   assign pready = st_ff.rdy;
   assign pslverr = st_ff.err;
   assign chan_a_sample_bus_out = st_ff.qa;
   assign chan_b_sample_bus_out = st_ff.qb;
   assign chan_a_sample_bus_oe_out = st_ff.oea;
   assign chan_b_sample_bus_oe_out = st_ff.oeb;
   assign chan_a_over_range_out = st_ff.ova;
   assign chan_b_over_range_out = st_ff.ovb;
   assign chan_a_output_clock_out = st_ff.dca;
   assign chan_b_output_clock_out = st_ff.dcb;
   assign powered_down_out = st_ff.pd_d;
   assign bias_enable_out = st_ff.ctrl[CTRL_BIAS_BIT];
   assign cm_ref_code_out = st_ff.cmref;
   pd_tristate_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      power_down_pin_in |=> (chan_a_sample_bus_oe_out == 10'h000 && chan_b_sample_bus_oe_out == 10'h000))
      else $error("outputs driven in power-down");
   pd_cfg_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      (!serial_mode && $fell(power_down_pin_in)) |=> (cm_ref_code_out == CMREF_RESET))
      else $error("config not reset");
   cm_range_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      cm_ref_code_out <= CMREF_MAX) else $error("common-mode code out of range");
   bias_parallel_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      !serial_mode ##1 !serial_mode |-> !bias_enable_out) else $error("bias on in parallel mode");
   pipe_depth_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      (nxt_st.pvld[0] && !(sync_in && !st_ff.sync_d)) |-> ##8 st_ff.pvld[HALF_STEPS-1])
      else $error("pipeline depth wrong");
   dclk_toggle_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      $changed(chan_a_sample_bus_out) |-> $changed(chan_a_output_clock_out)) else $error("data without clock");
   // apb answer in one cycle
   apb_answer_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      (psel && penable && !pready) |=> pready) else $error("apb late");
   dual_enable_a: assert property (@(posedge clock_in) disable iff (!rst_n)
      (bus == DACFG_BUS_DUAL && !power_down_pin_in) |=> chan_b_sample_bus_oe_out == 10'h3FF)
      else $error("dual bus not enabled");
   cover_dual_c: cover property (@(posedge clock_in) bus == DACFG_BUS_DUAL && buf_take);
   cover_muxb_c: cover property (@(posedge clock_in) bus == DACFG_BUS_MUXB && buf_take);
   cover_stall_c: cover property (@(posedge clock_in) !buf_in_ready);
endmodule
`default_nettype wire

// File: bench/dacfg_rx_model.sv
// dacfg_rx_model: capture logic on the receiving side of the sample buses
`timescale 1ns/10ps
`default_nettype none
module dacfg_rx_model
   import dacfg_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       stall_in,
   input  wire logic [9:0] a_bus_in,
   input  wire logic [9:0] b_bus_in,
   input  wire logic       a_clk_in,
   input  wire logic       b_clk_in,
   output var  logic       ready_out,
   output var  logic [9:0] a_last_out,
   output var  logic [9:0] a_prev_out,
   output var  logic [9:0] b_last_out,
   output var  logic [9:0] b_prev_out,
   output var  int         a_cnt_out,
   output var  int         b_cnt_out
);
   logic       a_clk_q;
   logic       b_clk_q;
   logic [2:0] phase;
   initial begin
      a_clk_q = 1'b0;
      b_clk_q = 1'b0;
      phase = 3'h0;
      a_cnt_out = 0;
      b_cnt_out = 0;
   end
   // stalls four cycles of eight when asked
   assign ready_out = !stall_in || phase[2];
   always @(posedge clock_in) begin
      phase <= phase + 3'h1;
      a_clk_q <= a_clk_in;
      b_clk_q <= b_clk_in;
      if (a_clk_in !== a_clk_q) begin
         a_prev_out <= a_last_out;
         a_last_out <= a_bus_in;
         a_cnt_out <= a_cnt_out + 1;
      end
      if (b_clk_in !== b_clk_q) begin
         b_prev_out <= b_last_out;
         b_last_out <= b_bus_in;
         b_cnt_out <= b_cnt_out + 1;
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// tb_top: self-checking bench for the dual converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dacfg_pkg::*;
   typedef struct {logic [1:0] f, d, m; logic [9:0] a, b; logic o; int r;} dacfg_row_s;
   logic clock_in, nrst_in, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic spn, pdn, sync, ova, ovb, stall, rdy, err, ora, orb, cka, ckb, pd, bias;
   logic [1:0] fmt_s, div_s, bus_s;
   logic [9:0] ra, rb, oa, ob, oea, oeb, al, ap, bl, bp, ea, eb;
   logic [2:0] cm;
   int acnt, bcnt, n, failures, compares;
   dacfg_row_s rows [7] = '{
      '{STRAP_GND, STRAP_GND, STRAP_GND, 10'h2A5, 10'h13C, 1'b0, 1},
      '{STRAP_SUP, STRAP_GND, STRAP_GND, 10'h0F0, 10'h3C3, 1'b1, 1},
      '{STRAP_OPEN, STRAP_GND, STRAP_GND, 10'h155, 10'h2AA, 1'b0, 1},
      '{STRAP_SUP, STRAP_SUP, STRAP_GND, 10'h3FF, 10'h001, 1'b1, 2},
      '{STRAP_SUP, STRAP_OPEN, STRAP_GND, 10'h200, 10'h1FF, 1'b0, 4},
      '{STRAP_SUP, STRAP_SUP, STRAP_SUP, 10'h0A5, 10'h35A, 1'b0, 2},
      '{STRAP_SUP, STRAP_SUP, STRAP_OPEN, 10'h3A0, 10'h05F, 1'b1, 2}};
   dacfg_top u_dacfg_top (.clock_in(clock_in), .nrst_in(nrst_in), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_port_select_n_in(spn), .power_down_pin_in(pdn),
      .serial_in_or_format_strap_in(fmt_s), .serial_clock_or_divider_strap_in(div_s),
      .chip_select_or_bus_mode_strap_in(bus_s), .sync_in(sync), .chan_a_raw_in(ra),
      .chan_b_raw_in(rb), .chan_a_ovr_raw_in(ova), .chan_b_ovr_raw_in(ovb), .rx_ready_in(rdy),
      .chan_a_sample_bus_out(oa), .chan_a_sample_bus_oe_out(oea), .chan_b_sample_bus_out(ob),
      .chan_b_sample_bus_oe_out(oeb), .chan_a_over_range_out(ora), .chan_b_over_range_out(orb),
      .chan_a_output_clock_out(cka), .chan_b_output_clock_out(ckb), .powered_down_out(pd),
      .bias_enable_out(bias), .cm_ref_code_out(cm));
   // a bus that is not driven shows the inverse of its last word
   dacfg_rx_model u_dacfg_rx_model (.clock_in(clock_in), .stall_in(stall), .a_bus_in(oa ^ ~oea),
      .b_bus_in(ob ^ ~oeb), .a_clk_in(cka), .b_clk_in(ckb), .ready_out(rdy), .a_last_out(al),
      .a_prev_out(ap), .b_last_out(bl), .b_prev_out(bp), .a_cnt_out(acnt), .b_cnt_out(bcnt));
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = !clock_in;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_cnt(input int g, input int lo, input int hi);
      compares++;
      if (g < lo || g > hi) begin
         failures++;
         $display("unexpected at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clock_in);
   endtask
   task automatic pd_pulse(input int c);
      @(posedge clock_in);
      pdn <= 1'b1;
      cyc(c);
      pdn <= 1'b0;
   endtask
   task automatic ser_wr(input logic [15:0] w);
      @(posedge clock_in);
      bus_s <= 2'h0;
      for (int i = 15; i >= 0; i--) begin
         cyc(1);
         div_s <= 2'h0;
         fmt_s <= {1'b0, w[i]};
         cyc(2);
         div_s <= 2'h1;
         cyc(1);
      end
      cyc(2);
      bus_s <= 2'h1;
      div_s <= 2'h0;
   endtask
   function automatic logic [9:0] conv(input logic [1:0] f, input logic [9:0] r);
      if (f == STRAP_GND) return r ^ 10'h200;
      if (f == STRAP_SUP) return r;
      return r ^ (r >> 1);
   endfunction
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      test_done();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pdn, sync, ova, ovb, stall} = '0;
      {fmt_s, div_s, bus_s, ra, rb} = '0;
      failures = 0;
      compares = 0;
      nrst_in = 1'b0;
      spn = 1'b1;
      cyc(8);
      nrst_in <= 1'b0 | 1'b1;
      cyc(4);
      chk({29'h0, cm}, {29'h0, CMREF_RESET});
      chk({31'h0, bias}, 32'h0);
      apb(1'b0, CMREF_ADDR, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, CMREF_RESET});
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge clock_in);
         fmt_s <= rows[i].f;
         div_s <= rows[i].d;
         bus_s <= rows[i].m;
         ra <= rows[i].a;
         rb <= rows[i].b;
         ova <= rows[i].o;
         ovb <= rows[i].o;
         sync <= 1'b1;
         pd_pulse(4);
         sync <= 1'b0;
         cyc(40);
         n = (rows[i].m == STRAP_OPEN) ? bcnt : acnt;
         cyc(64);
         n = ((rows[i].m == STRAP_OPEN) ? bcnt : acnt) - n;
         ea = conv(rows[i].f, rows[i].a);
         eb = conv(rows[i].f, rows[i].b);
         if (rows[i].m == STRAP_GND) begin
            chk({22'h0, al}, {22'h0, ea});
            chk({22'h0, bl}, {22'h0, eb});
            chk({12'h0, oea, oeb}, {12'h0, 20'hFFFFF});
            apb(1'b0, SAMPA_ADDR, 32'h0);
            chk(rd, {21'h0, rows[i].o, ea});
         end else if (rows[i].m == STRAP_SUP) begin
            chk({31'h0, (al === ea && ap === eb) || (al === eb && ap === ea)}, 32'h1);
            chk({22'h0, oeb}, 32'h0);
         end else begin
            chk({31'h0, (bl === ea && bp === eb) || (bl === eb && bp === ea)}, 32'h1);
            chk({22'h0, oea}, 32'h0);
         end
         chk({30'h0, ora, orb}, {30'h0, rows[i].o, rows[i].o});
         n = n * rows[i].r;
         chk_cnt(n, ((rows[i].m == STRAP_GND) ? 64 : 128) - 8, (rows[i].m == STRAP_GND) ? 72 : 136);
         $display("test row %0d done", i);
      end
      stall <= 1'b1;
      n = bcnt;
      cyc(64);
      chk_cnt(bcnt - n, 24, 40);
      chk({31'h0, bl === 10'h3A0 || bl === 10'h05F}, 32'h1);
      stall <= 1'b0;
      $display("test stall done");
      @(posedge clock_in);
      pdn <= 1'b1;
      cyc(20);
      chk({31'h0, pd}, 32'h1);
      chk({12'h0, oea, oeb}, 32'h0);
      n = acnt + bcnt;
      cyc(16);
      chk_cnt(acnt + bcnt - n, 0, 0);
      pdn <= 1'b0;
      cyc(4);
      chk({31'h0, pd}, 32'h0);
      $display("test power down done");
      @(posedge clock_in);
      spn <= 1'b0;
      bus_s <= 2'h1;
      div_s <= 2'h0;
      ser_wr({1'b0, 7'h08, 8'h45});
      cyc(4);
      chk({31'h0, bias}, 32'h1);
      chk({29'h0, cm}, 32'h5);
      apb(1'b1, CMREF_ADDR, 32'h2);
      cyc(3);
      chk({29'h0, cm}, 32'h2);
      apb(1'b1, CMREF_ADDR, 32'h7);
      cyc(3);
      chk({29'h0, cm}, 32'h2);
      pd_pulse(4);
      cyc(6);
      chk({29'h0, cm}, 32'h2);
      apb(1'b1, CTRL_ADDR, 32'h80);
      cyc(3);
      chk({29'h0, cm}, {29'h0, CMREF_RESET});
      chk({31'h0, bias}, 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h40);
      cyc(3);
      chk({31'h0, bias}, 32'h0);
      apb(1'b1, CMREF_ADDR, 32'h2);
      $display("test serial done");
      @(posedge clock_in);
      spn <= 1'b1;
      pd_pulse(4);
      cyc(6);
      chk({29'h0, cm}, {29'h0, CMREF_RESET});
      chk({31'h0, bias}, 32'h0);
      $display("test strap reset done");
      test_done();
   end
endmodule
`default_nettype wire
